// ===== logic/dcf_pkg.sv
// Purpose: Shared constants and types for the programmable-flag FIFO
// Assumes: Single system clock; pins sampled synchronously
// Notes: Depth fixed at 512 words of 18 bits
package dcf_pkg;
  // ==========================================================
  // Geometry
  localparam int DATA_W = 18;
  localparam int DEPTH = 512;
  localparam int ADDR_W = 9;
  localparam int CNT_W = 10;
  localparam int OFS_W = 12;
  localparam int STG_DEPTH = 32;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 10'h200;
  localparam logic [CNT_W-1:0] HALF_CNT = 10'h100;
  // ==========================================================
  // Reset values
  localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 12'h03F;
  localparam logic [OFS_W-1:0] FULL_OFS_RST = 12'h03F;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  // ==========================================================
  // Offset register select
  typedef enum logic [1:0] {
    SEL_EMPTY = 2'b01,
    SEL_FULL = 2'b10
  } dcf_sel_t;
  // Status flags, all active low
  typedef struct packed {
    logic empty_n;
    logic aempty_n;
    logic half_n;
    logic afull_n;
    logic full_n;
  } dcf_flags_t;
  localparam dcf_flags_t FLAGS_RST = 5'b0_0111;
endpackage

// ===== logic/dcf_fifo.sv
// Purpose: Programmable-flag FIFO with staging buffer and offset registers
// Assumes: Write and read strobes sampled on clk_sys
// Notes: Staging buffer on the write path absorbs bursts into the core
//
// Behaviour
// - Reset leaves FIFO empty, empty flag low
// - Reset drives data outputs low when enabled
// - Write enable low stores input word
// - Read enable low presents next word
// - Output enable high floats data outputs
// - Cascaded: only read-enabled device drives
// - Full flag low blocks all FIFO writes
// - Empty flag low blocks all FIFO reads
// - Empty FIFO holds last valid word
// - Two 12-bit offsets from low inputs
// - Offset writes cycle empty then full
// - Load high ends; sequence resumes later
// - Offset reads follow same alternating order
// - Load/enable decode: offset write, no-op or FIFO write
// - Offsets default to 63 at 512 depth
// - Almost flags from offsets n and m
// - Half flag low above half depth
// - Sync mode: almost flags clocked normally
// - Async mode: almost flags lag one extra cycle
// - Retransmit pulse rewinds read pointer
// - Replay until read meets write pointer
`timescale 1ns/1ps

// ============================================================
// Staging buffer
module dcf_stage #(
  parameter int W = 18,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] buf_mem [D];
  logic [AW-1:0] head_q;
  logic [AW-1:0] tail_q;
  logic [AW:0] level_q;
  logic push;
  logic pop;

  assign in_ready = (level_q != D[AW:0]);
  assign out_valid = (level_q != '0);
  assign out_data = buf_mem[head_q];
  assign level = level_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      buf_mem[tail_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      head_q <= '0;
      tail_q <= '0;
      level_q <= '0;
    end else begin
      if (push) begin
        tail_q <= tail_q + 1'b1;
      end
      if (pop) begin
        head_q <= head_q + 1'b1;
      end
      level_q <= level_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ============================================================
// Top
module dcf_fifo
  import dcf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic fifo_reset_n,
  // Write port
  input wire logic wr_en_n,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  // Read port
  input wire logic rd_en_n,
  input wire logic out_enable_n,
  input wire logic cascade_mode,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  // Control
  input wire logic offset_load_n,
  input wire logic retransmit_pulse,
  input wire logic flag_sync_select,
  // Flags
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_flag_n,
  output logic almost_full_flag_n,
  output logic full_flag_n
);
  function automatic logic [CNT_W-1:0] ext_ofs(input logic [OFS_W-1:0] o);
    ext_ofs = (o > OFS_W'(DEPTH)) ? DEPTH_CNT : o[CNT_W-1:0];
  endfunction

  // ==========================================================
  // State
  logic [DATA_W-1:0] core_mem [DEPTH];
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] rptr_q;
  logic [CNT_W-1:0] mem_cnt_q;
  logic [CNT_W-1:0] wr_total_q;
  logic [CNT_W-1:0] total_q;
  logic [CNT_W-1:0] total_old_q;
  logic [OFS_W-1:0] empty_ofs_q;
  logic [OFS_W-1:0] full_ofs_q;
  dcf_sel_t wr_sel_q;
  dcf_sel_t rd_sel_q;
  dcf_flags_t flags_q;
  logic [DATA_W-1:0] rd_data_q;
  logic oe_q;
  logic wr_ready_q;
  logic clear;
  logic accept;
  logic stg_ready;
  logic stg_valid;
  logic [DATA_W-1:0] stg_data;
  logic [$clog2(STG_DEPTH):0] stg_level;
  logic mem_wr;
  logic rd_fire;
  logic ofs_wr;
  logic ofs_rd;
  logic [CNT_W-1:0] flag_cnt;

  assign clear = !reset_n || !fifo_reset_n;
  // Full flag and live count both guard the write path
  assign accept = !wr_en_n && offset_load_n && flags_q.full_n
    && (total_q < DEPTH_CNT) && stg_ready;
  assign mem_wr = stg_valid && (mem_cnt_q < DEPTH_CNT);
  assign rd_fire = !rd_en_n && offset_load_n && flags_q.empty_n
    && (mem_cnt_q != '0) && !retransmit_pulse;
  assign ofs_wr = !offset_load_n && !wr_en_n;
  assign ofs_rd = !offset_load_n && !rd_en_n;

  dcf_stage #(.W(DATA_W), .D(STG_DEPTH)) u_stage (
    .clk_sys(clk_sys),
    .clear(clear),
    .in_valid(accept),
    .in_ready(stg_ready),
    .in_data(wr_data),
    .out_valid(stg_valid),
    .out_ready(mem_wr),
    .out_data(stg_data),
    .level(stg_level)
  );

  // ==========================================================
  // Core memory and pointers
  always_ff @(posedge clk_sys) begin
    if (mem_wr) begin
      core_mem[wptr_q] <= stg_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      wptr_q <= '0;
      wr_total_q <= '0;
    end else if (mem_wr) begin
      wptr_q <= wptr_q + 1'b1;
      if (wr_total_q != DEPTH_CNT) begin
        wr_total_q <= wr_total_q + 1'b1;
      end
    end
  end

  // Rewind assumes no more than a full depth written since reset
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      rptr_q <= '0;
      mem_cnt_q <= '0;
    end else if (retransmit_pulse) begin
      rptr_q <= '0;
      mem_cnt_q <= wr_total_q + CNT_W'(mem_wr);
    end else begin
      if (rd_fire) begin
        rptr_q <= rptr_q + 1'b1;
      end
      mem_cnt_q <= mem_cnt_q + CNT_W'(mem_wr) - CNT_W'(rd_fire);
    end
  end

  // ==========================================================
  // Offset registers
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      empty_ofs_q <= EMPTY_OFS_RST;
      full_ofs_q <= FULL_OFS_RST;
      wr_sel_q <= SEL_EMPTY;
    end else if (ofs_wr) begin
      case (wr_sel_q)
        SEL_EMPTY: begin
          empty_ofs_q <= wr_data[OFS_W-1:0];
          wr_sel_q <= SEL_FULL;
        end
        SEL_FULL: begin
          full_ofs_q <= wr_data[OFS_W-1:0];
          wr_sel_q <= SEL_EMPTY;
        end
        default: begin
          wr_sel_q <= SEL_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      rd_sel_q <= SEL_EMPTY;
    end else if (ofs_rd) begin
      case (rd_sel_q)
        SEL_EMPTY: rd_sel_q <= SEL_FULL;
        SEL_FULL: rd_sel_q <= SEL_EMPTY;
        default: rd_sel_q <= SEL_EMPTY;
      endcase
    end
  end

  // ==========================================================
  // Output register and enable
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      rd_data_q <= DATA_RST;
    end else if (ofs_rd) begin
      rd_data_q <= (rd_sel_q == SEL_FULL)
        ? DATA_W'(full_ofs_q) : DATA_W'(empty_ofs_q);
    end else if (rd_fire) begin
      rd_data_q <= core_mem[rptr_q];
    end
    // Otherwise hold the last valid word
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !out_enable_n && (!cascade_mode || !rd_en_n);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      wr_ready_q <= 1'b0;
    end else begin
      // Registered, so leave one slot of margin
      wr_ready_q <= (stg_level < ($clog2(STG_DEPTH)+1)'(STG_DEPTH - 1));
    end
  end

  // ==========================================================
  // Flags
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      total_q <= '0;
      total_old_q <= '0;
    end else begin
      total_q <= mem_cnt_q + CNT_W'(stg_level) + CNT_W'(accept)
        - CNT_W'(rd_fire) + (retransmit_pulse
        ? (wr_total_q - mem_cnt_q) : '0);
      total_old_q <= total_q;
    end
  end

  // Sync mode uses the current count, async the one a cycle older
  assign flag_cnt = flag_sync_select ? total_q : total_old_q;

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q.full_n <= (total_q != DEPTH_CNT);
      flags_q.empty_n <= (mem_cnt_q != '0) || mem_wr;
      flags_q.half_n <= !(total_q > HALF_CNT);
      flags_q.aempty_n <= (flag_cnt > ext_ofs(empty_ofs_q));
      flags_q.afull_n <= (flag_cnt < (DEPTH_CNT
        - ext_ofs(full_ofs_q)));
    end
  end

  assign empty_flag_n = flags_q.empty_n;
  assign almost_empty_flag_n = flags_q.aempty_n;
  assign half_full_flag_n = flags_q.half_n;
  assign almost_full_flag_n = flags_q.afull_n;
  assign full_flag_n = flags_q.full_n;
  assign rd_data = rd_data_q;
  assign rd_data_oe = oe_q;
  assign wr_ready = wr_ready_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_load_wr;
    !offset_load_n && !wr_en_n;
  endsequence

  property p_reset_empty;
    disable iff (1'b0) !reset_n |=> !empty_flag_n && rd_data == DATA_RST;
  endproperty
  a_reset_empty: assert property (p_reset_empty)
    else $error("reset did not empty fifo");

  property p_full_blocks;
    !full_flag_n |-> !accept;
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("write taken while full");

  property p_empty_blocks;
    !empty_flag_n |-> !rd_fire;
  endproperty
  a_empty_blocks: assert property (p_empty_blocks)
    else $error("read taken while empty");

  property p_hold;
    !rd_fire && offset_load_n && fifo_reset_n |=> $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without read");

  property p_oe;
    out_enable_n |=> !rd_data_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("output driven while disabled");

  property p_half;
    fifo_reset_n && total_q > HALF_CNT |=> !half_full_flag_n;
  endproperty
  a_half: assert property (p_half)
    else $error("half flag missed");

  property p_rt;
    retransmit_pulse && fifo_reset_n |=> rptr_q == '0;
  endproperty
  a_rt: assert property (p_rt)
    else $error("retransmit did not rewind");

  property p_offset_seq;
    s_load_wr ##0 (wr_sel_q == SEL_EMPTY) && fifo_reset_n
      |=> wr_sel_q == SEL_FULL ##0 full_ofs_q == $past(full_ofs_q);
  endproperty
  a_offset_seq: assert property (p_offset_seq)
    else $error("offset sequence wrong");
endmodule

// ===== verif/dcf_peer.sv
// Purpose: Producer and consumer model around the FIFO ports
// Assumes: Caller enters each task just after a clock edge
// Notes: Released data bus shows the inverse of the last word
`timescale 1ns/1ps
module dcf_peer
  import dcf_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Producer
  output logic wr_en_n,
  output logic [DATA_W-1:0] wr_data,
  output logic offset_load_n,
  // Consumer
  output logic rd_en_n,
  input wire logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] wq[$];
  logic [DATA_W-1:0] rq[$];
  // ==========================================================
  // Idle until asked; no access during reset
  initial begin
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    offset_load_n = 1'b1;
    wr_data = 18'h0_0000;
  end
  // ==========================================================
  // Producer: queued words back to back
  task automatic send(input logic ld);
    logic [DATA_W-1:0] w;
    w = 18'h0_0000;
    while (wq.size() > 0) begin
      w = wq.pop_front();
      wr_en_n = 1'b0;
      offset_load_n = ld;
      wr_data = w;
      @(posedge clk_sys);
      #1;
    end
    wr_en_n = 1'b1;
    offset_load_n = 1'b1;
    wr_data = ~w;
  endtask
  // ==========================================================
  // Consumer: n reads, word captured after each edge
  task automatic fetch(input int n, input logic ld);
    rd_en_n = 1'b0;
    offset_load_n = ld;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      rq.push_back(rd_data);
    end
    rd_en_n = 1'b1;
    offset_load_n = 1'b1;
  endtask
endmodule

// ===== verif/dual_clock_fifo_prog_flags_tb.sv
// Purpose: Self-checking bench for the programmable-flag FIFO
// Assumes: Flags settle within five edges of a transfer
// Notes: Fill and drain run once per flag mode
`timescale 1ns/1ps
module dual_clock_fifo_prog_flags_tb;
  import dcf_pkg::*;
  logic clk_sys = 0;
  logic reset_n = 0;
  logic fifo_reset_n = 1;
  logic out_enable_n = 0;
  logic cascade_mode = 0;
  logic retransmit_pulse = 0;
  logic flag_sync_select = 0;
  logic wr_en_n, offset_load_n, rd_en_n, wr_ready, rd_data_oe;
  logic ef_n, aef_n, hf_n, aff_n, ff_n;
  logic [DATA_W-1:0] wr_data, rd_data, w;
  logic [DATA_W-1:0] exq[$];
  dcf_flags_t fl;
  int failures = 0;
  int checks = 0;
  int seed = 32'hac56;
  int n, m, c, md, i;
  assign fl = {ef_n, aef_n, hf_n, aff_n, ff_n};
  always #2.5 clk_sys = ~clk_sys;
  dcf_fifo dut(.clk_sys(clk_sys), .reset_n(reset_n),
    .fifo_reset_n(fifo_reset_n), .wr_en_n(wr_en_n), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_en_n(rd_en_n), .out_enable_n(out_enable_n),
    .cascade_mode(cascade_mode), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .offset_load_n(offset_load_n),
    .retransmit_pulse(retransmit_pulse),
    .flag_sync_select(flag_sync_select), .empty_flag_n(ef_n),
    .almost_empty_flag_n(aef_n), .half_full_flag_n(hf_n),
    .almost_full_flag_n(aff_n), .full_flag_n(ff_n));
  dcf_peer u_peer(.clk_sys(clk_sys), .wr_en_n(wr_en_n),
    .wr_data(wr_data), .offset_load_n(offset_load_n),
    .rd_en_n(rd_en_n), .rd_data(rd_data));
  // ==========================================================
  // Helpers
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic dcf_flags_t exp_fl(input int k);
    exp_fl.empty_n = (k != 0);
    exp_fl.aempty_n = (k > n);
    exp_fl.half_n = (k <= DEPTH / 2);
    exp_fl.afull_n = (k < DEPTH - m);
    exp_fl.full_n = (k < DEPTH);
  endfunction
  task automatic chk_fl(input int k);
    chk("flags", 18'(exp_fl(k)), 18'(fl));
  endtask
  task automatic results;
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    for (md = 0; md < 2; md++) begin
      reset_n = 0;
      flag_sync_select = md[0];
      step(20);
      reset_n = 1;
      step(2);
      n = 63;
      m = 63;
      chk_fl(0);
      chk("rd_data", DATA_RST, rd_data);
      chk("oe", 18'h0_0001, 18'(rd_data_oe));
      chk("wr_ready", 18'h0_0001, 18'(wr_ready));
      u_peer.fetch(2, 1'b0);
      chk("ofs", 18'(EMPTY_OFS_RST), u_peer.rq.pop_front());
      chk("ofs", 18'(FULL_OFS_RST), u_peer.rq.pop_front());
      if (md == 0) begin
        n = 1 + {$random(seed)} % 60;
        m = 1 + {$random(seed)} % 60;
        w = $random(seed);
        u_peer.wq.push_back({w[17:12], 12'(n)});
        step(1);
        u_peer.send(1'b0);
        step(1);
        u_peer.wq.push_back({w[11:6], 12'(m)});
        u_peer.send(1'b0);
        step(1);
        u_peer.fetch(2, 1'b0);
        chk("ofs", 18'(n), u_peer.rq.pop_front());
        chk("ofs", 18'(m), u_peer.rq.pop_front());
      end
      step(4);
      chk_fl(0);
      for (c = 1; c <= DEPTH; c++) begin
        w = $random(seed);
        exq.push_back(w);
        u_peer.wq.push_back(w);
        u_peer.send(1'b1);
        step(5);
        chk_fl(c);
      end
      u_peer.wq.push_back(~exq[0]);
      u_peer.send(1'b1);
      step(5);
      chk_fl(DEPTH);
      for (c = DEPTH - 1; c >= 0; c--) begin
        u_peer.fetch(1, 1'b1);
        w = u_peer.rq.pop_front();
        chk("rd_data", exq.pop_front(), w);
        step(4);
        chk_fl(c);
      end
      u_peer.fetch(2, 1'b1);
      chk("hold", w, u_peer.rq.pop_front());
      chk("hold", w, u_peer.rq.pop_front());
      step(1);
    end
    // Pin reset mid-run, then rewind and replay
    fifo_reset_n = 0;
    step(2);
    fifo_reset_n = 1;
    step(2);
    chk_fl(0);
    chk("rd_data", DATA_RST, rd_data);
    for (i = 0; i < 6; i++) begin
      w = $random(seed);
      exq.push_back(w);
      u_peer.wq.push_back(w);
    end
    u_peer.send(1'b1);
    step(5);
    u_peer.fetch(2, 1'b1);
    chk("rd_data", exq[0], u_peer.rq.pop_front());
    chk("rd_data", exq[1], u_peer.rq.pop_front());
    retransmit_pulse = 1;
    step(1);
    retransmit_pulse = 0;
    step(4);
    w = $random(seed);
    exq.push_back(w);
    u_peer.wq.push_back(w);
    u_peer.send(1'b1);
    step(5);
    chk_fl(7);
    u_peer.fetch(7, 1'b1);
    for (i = 0; i < 7; i++) begin
      chk("replay", exq.pop_front(), u_peer.rq.pop_front());
    end
    step(4);
    chk_fl(0);
    out_enable_n = 1;
    step(2);
    chk("oe", 18'h0_0000, 18'(rd_data_oe));
    out_enable_n = 0;
    cascade_mode = 1;
    step(2);
    chk("oe", 18'h0_0000, 18'(rd_data_oe));
    // Random enable mixes, read enable idle so cascade blocks the drive
    for (i = 0; i < 8; i++) begin
      w = $random(seed);
      out_enable_n = w[0];
      cascade_mode = w[1];
      step(2);
      chk("oe", 18'(!w[0] && !w[1]), 18'(rd_data_oe));
    end
    results();
  end
endmodule
